// ---- src/display_reset_pkg.sv ----
// constants, layout and state type for the display reset sequencer
package display_reset_pkg;
    // clock rate
    localparam int CLK_MHZ        = 50;
    // reset pin filter: pulses below the reject time never reset
    localparam int REJECT_US      = 5;
    localparam int ACCEPT_US      = 9;
    localparam int REJECT_CYC     = REJECT_US * CLK_MHZ;
    localparam int ACCEPT_CYC     = ACCEPT_US * CLK_MHZ;
    localparam int FILT_W         = 16;
    // blanking from the awake state, capped by the awake release period
    localparam int BLANK_MAX_MS   = 120;
    localparam int BLANK_MS       = 100;
    localparam int BLANK_CYC      = BLANK_MS * 1000 * CLK_MHZ;
    localparam int BLANK_W        = 24;
    // release period limits, sleep and awake
    localparam int REL_SLEEP_MS   = 5;
    localparam int REL_AWAKE_MS   = 120;
    localparam int REL_SLEEP_CYC  = REL_SLEEP_MS * 1000 * CLK_MHZ;
    localparam int REL_AWAKE_CYC  = REL_AWAKE_MS * 1000 * CLK_MHZ;
    // non-volatile image: ids, common electrode level, settings
    localparam int NVM_WORDS      = 5;
    localparam int NVM_WORD_W     = 8;
    localparam int NVM_ADDR_W     = 3;
    localparam int NVM_ID0        = 0;
    localparam int NVM_ID1        = 1;
    localparam int NVM_ID2        = 2;
    localparam int NVM_COMMON_ELECTRODE_LEVEL       = 3;
    localparam int NVM_SETTINGS   = 4;
    localparam logic [NVM_ADDR_W-1:0] NVM_ADDR_ZERO = 3'h0;
    localparam logic [NVM_ADDR_W-1:0] NVM_ADDR_ONE  = 3'h1;
    localparam logic [NVM_WORD_W-1:0] NVM_RESET_VAL = 8'h00;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_BLANK,
        ST_HOLD,
        ST_LOAD_REQ,
        ST_LOAD_WAIT
    } seq_state_t;
endpackage : display_reset_pkg

// ---- src/reset_pin_filter.sv ----
// spike filter for the active-low hardware reset pin
`timescale 1ns/10ps
`default_nettype none
module reset_pin_filter
    import display_reset_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = REJECT_CYC
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic clk_en,
    // pin and filtered level
    input  wire logic hw_reset_low_pin,
    output var  logic reset_held
);
    localparam logic [FILT_W-1:0] LAST = FILT_W'(SETTLE_CYC - 1);
    localparam logic [FILT_W-1:0] ZERO = 16'h0000;

    logic [FILT_W-1:0] cnt;
    logic              differs;

    // pin disagrees with the filtered level
    assign differs = (~hw_reset_low_pin) != reset_held;

    // level must hold for the settle time in either direction, so a short
    // spike neither starts a reset nor ends one that is in progress
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt        <= ZERO;
            reset_held <= 1'b0;
        end else if (clk_en) begin
            if (!differs) begin
                cnt <= ZERO;
            end else if (cnt == LAST) begin
                cnt        <= ZERO;
                reset_held <= ~reset_held;
            end else begin
                cnt <= cnt + 16'h0001;
            end
        end
    end
endmodule : reset_pin_filter
`default_nettype wire

// ---- src/display_reset_sequencer.sv ----
// hardware reset sequencer: filter, blanking, defaults and image load
`timescale 1ns/10ps
`default_nettype none
module display_reset_sequencer
    import display_reset_pkg::*;
#(
    parameter int unsigned BLANK_CYCLES = BLANK_CYC,
    parameter int unsigned FILTER_CYC   = REJECT_CYC,
    parameter int unsigned WORDS        = NVM_WORDS
) (
    // clock, reset, enable
    input  wire logic                          clk_sys,
    input  wire logic                          rstn,
    input  wire logic                          clk_en,
    // reset pin and controller mode
    input  wire logic                          hw_reset_low_pin,
    input  wire logic                          awake_mode,
    // non-volatile memory read port
    output var  logic                          nvm_rd,
    output var  logic [NVM_ADDR_W-1:0]         nvm_addr,
    input  wire logic [NVM_WORD_W-1:0]         nvm_rdata,
    input  wire logic                          nvm_rvalid,
    // status toward the controller
    output var  logic                          display_blank,
    output var  logic                          in_reset,
    output var  logic                          defaults_load,
    output var  logic                          config_ready,
    output var  logic [WORDS*NVM_WORD_W-1:0]   nvm_image
);
    import display_reset_pkg::*;

    // counter end points, cut to the counter widths
    localparam logic [BLANK_W-1:0] BLANK_LAST = BLANK_W'(BLANK_CYCLES - 1);
    localparam logic [BLANK_W-1:0] BLANK_ZERO = 24'h000000;
    localparam logic [NVM_ADDR_W-1:0] ADDR_LAST = NVM_ADDR_W'(WORDS - 1);

    // sequencer state, filtered pin, blanking timer and word strobe
    seq_state_t               state;
    seq_state_t               next_state;
    logic                     reset_held;
    logic [BLANK_W-1:0]       blank_cnt;
    logic                     capture;

    // true when a returned word belongs to image slot idx
    function automatic logic slot_hit(input logic [NVM_ADDR_W-1:0] addr,
                                      input int idx);
        slot_hit = (addr == NVM_ADDR_W'(idx));
    endfunction : slot_hit

    // true on the final word of the image
    function automatic logic last_word(input logic [NVM_ADDR_W-1:0] addr);
        last_word = (addr == ADDR_LAST);
    endfunction : last_word

    // true when the display is live and configured
    function automatic logic is_run(input seq_state_t s);
        is_run = (s == ST_RUN);
    endfunction : is_run

    // pin filter: accepts at the reject threshold, so pulses between the
    // two limits also start a reset; release is filtered the same way,
    // so the load begins one settle time after the pin goes high, or at the end of awake blanking if later, and a
    // spike on either side of a held reset is lost in the filter
    reset_pin_filter #(
        .SETTLE_CYC       (FILTER_CYC)
    ) u_filter (
        .clk_sys          (clk_sys),
        .rstn             (rstn),
        .clk_en           (clk_en),
        .hw_reset_low_pin (hw_reset_low_pin),
        .reset_held       (reset_held)
    );

    // a word counts only while one is awaited; stray strobes are dropped
    assign capture = (state == ST_LOAD_WAIT) && nvm_rvalid;

    // sequencing; an accepted reset pre-empts any load in progress
    //   run        display live, image loaded, ready
    //   blank      awake reset only: timed blanking before the defaults
    //   hold       defaults taken; waits for a settled pin release
    //   load req   one word asked of the memory
    //   load wait  word in flight; a reset here returns to hold
    // every abort restarts the load from word zero, so a half written
    // image never reaches the controller as ready; there is no memory
    // timeout, a memory that never answers keeps the display blank
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (reset_held) begin
                    // sleep mode is already blank, so skip the timed blanking
                    next_state = awake_mode ? ST_BLANK : ST_HOLD;
                end
            end
            ST_BLANK: begin
                // a release during blanking waits for its end
                if (blank_cnt == BLANK_LAST) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // the pin must read high for the settle time first
                if (!reset_held) begin
                    next_state = ST_LOAD_REQ;
                end
            end
            ST_LOAD_REQ: begin
                if (reset_held) begin
                    next_state = ST_HOLD;
                end else begin
                    next_state = ST_LOAD_WAIT;
                end
            end
            ST_LOAD_WAIT: begin
                // a new reset wins over a word arriving in the same cycle
                if (reset_held) begin
                    next_state = ST_HOLD;
                end else if (nvm_rvalid) begin
                    next_state = last_word(nvm_addr) ? ST_RUN
                                                     : ST_LOAD_REQ;
                end
            end
        endcase
    end

    // state register; out of reset the sequencer holds, so a full image
    // load follows every controller reset
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state <= ST_HOLD;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // blanking timer; the blank length is kept below the awake release
    // limit so the image load still fits inside that period; the count
    // clears on leaving blank, so a later reset blanks in full
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            blank_cnt <= BLANK_ZERO;
        end else if (clk_en) begin
            if (state == ST_BLANK) begin
                blank_cnt <= blank_cnt + 24'h000001;
            end else begin
                blank_cnt <= BLANK_ZERO;
            end
        end
    end

    // memory read requests walk the image from word zero; the address
    // stands from the request until its word returns
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            nvm_rd   <= 1'b0;
            nvm_addr <= NVM_ADDR_ZERO;
        end else if (clk_en) begin
            nvm_rd <= (next_state == ST_LOAD_REQ);
            if (state == ST_HOLD) begin
                nvm_addr <= NVM_ADDR_ZERO;
            end else if (capture && !last_word(nvm_addr)) begin
                nvm_addr <= nvm_addr + NVM_ADDR_ONE;
            end
        end
    end

    // image slots: ids, electrode level, settings; each slot takes only
    // the word whose address matches, so a late word cannot land twice
    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++) begin : g_slot
            always_ff @(posedge clk_sys) begin
                if (!rstn) begin
                    nvm_image[gi*NVM_WORD_W +: NVM_WORD_W] <= NVM_RESET_VAL;
                end else if (clk_en) begin
                    if (capture && slot_hit(nvm_addr, gi)) begin
                        nvm_image[gi*NVM_WORD_W +: NVM_WORD_W] <=
                            nvm_rdata;
                    end
                end
            end
        end
    endgenerate

    // blanking and reset status, registered from the next state so they
    // change on the same edge as the state register
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            display_blank <= 1'b1;
            in_reset      <= 1'b1;
        end else if (clk_en) begin
            display_blank <= !is_run(next_state);
            in_reset      <= !is_run(next_state);
        end
    end

    // one pulse as the hold phase is entered, after any blanking; a load
    // aborted by a new reset gives a fresh pulse
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            defaults_load <= 1'b0;
        end else if (clk_en) begin
            defaults_load <= (next_state == ST_HOLD) &&
                             (state != ST_HOLD);
        end
    end

    // ready only once the last word is in; the host must still keep its
    // own wait times after release
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            config_ready <= 1'b0;
        end else if (clk_en) begin
            config_ready <= is_run(next_state);
        end
    end
endmodule : display_reset_sequencer
`default_nettype wire

// ---- tb/display_reset_sva.sv ----
// port assertions for the display reset sequencer
`timescale 1ns/10ps
`default_nettype none
module display_reset_sva
    import display_reset_pkg::*;
#(
    parameter int unsigned BLANK_CYCLES = BLANK_CYC,
    parameter int unsigned FILTER_CYC   = REJECT_CYC,
    parameter int unsigned WORDS        = NVM_WORDS
) (
    // watched ports
    input wire logic                        clk_sys,
    input wire logic                        rstn,
    input wire logic                        clk_en,
    input wire logic                        hw_reset_low_pin,
    input wire logic                        awake_mode,
    input wire logic                        nvm_rd,
    input wire logic [NVM_ADDR_W-1:0]       nvm_addr,
    input wire logic                        nvm_rvalid,
    input wire logic                        display_blank,
    input wire logic                        in_reset,
    input wire logic                        defaults_load,
    input wire logic                        config_ready
);
    localparam int BMAX = BLANK_CYCLES + 2;
    localparam int RLIM = BLANK_CYCLES + FILTER_CYC + 64;
    int lo_cnt  = 0;
    int hi_cnt  = 0;
    int rel_cnt = 0;
    // pin run lengths over enabled edges only, as the filter sees them;
    // saturate so a long idle never wraps
    always_ff @(posedge clk_sys) begin
        if (clk_en) begin
            lo_cnt <= hw_reset_low_pin ? 0 :
                      (lo_cnt < 99999 ? lo_cnt + 1 : lo_cnt);
            hi_cnt <= !hw_reset_low_pin ? 0 :
                      (hi_cnt < 99999 ? hi_cnt + 1 : hi_cnt);
        end
    end
    // release time: reset active with pin already high
    always_ff @(posedge clk_sys) begin
        if (!rstn || !hw_reset_low_pin || !in_reset) begin
            rel_cnt <= 0;
        end else if (clk_en) begin
            rel_cnt <= rel_cnt + 1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn || !clk_en);
    sequence s_blank_then_defaults;
        !defaults_load [*8] ##[1:BMAX] defaults_load;
    endsequence
    a_short_low_ignored: assert property (
        $rose(in_reset) |-> $past(lo_cnt) >= FILTER_CYC)
        else $error("reset taken from too short a pin low");
    a_long_low_taken: assert property (lo_cnt == FILTER_CYC + 3 |-> in_reset)
        else $error("long pin low not taken as reset");
    a_spike_no_release: assert property ($fell(in_reset) |-> hi_cnt > FILTER_CYC)
        else $error("reset ended without a settled pin release");
    a_blank_in_reset: assert property (display_blank == in_reset)
        else $error("blanking differs from reset activity");
    a_awake_blank_len: assert property ($rose(display_blank) && $past(awake_mode) |-> s_blank_then_defaults)
        else $error("awake blanking length wrong");
    a_sleep_defaults: assert property ($rose(display_blank) && !$past(awake_mode) |-> defaults_load)
        else $error("defaults not taken at sleep reset");
    a_load_in_reset: assert property (nvm_rd |-> in_reset && !config_ready)
        else $error("memory read outside release period");
    a_ready_last_word: assert property ($rose(config_ready) |-> $past(nvm_rvalid) && $past(nvm_addr) == 3'(WORDS - 1))
        else $error("ready without last word loaded");
    a_release_bound: assert property (rel_cnt <= RLIM)
        else $error("release period too long");
endmodule : display_reset_sva
bind display_reset_sequencer display_reset_sva #(.BLANK_CYCLES(BLANK_CYCLES),
    .FILTER_CYC(FILTER_CYC), .WORDS(WORDS)) u_sva (.clk_sys(clk_sys),
    .rstn(rstn), .clk_en(clk_en), .hw_reset_low_pin(hw_reset_low_pin),
    .awake_mode(awake_mode),
    .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_rvalid(nvm_rvalid),
    .display_blank(display_blank), .in_reset(in_reset),
    .defaults_load(defaults_load), .config_ready(config_ready));
`default_nettype wire

// ---- tb/nvm_model.sv ----
// non-volatile memory model: one word read at a time, prompt or slow
`timescale 1ns/10ps
`default_nettype none
module nvm_model
    import display_reset_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  slow,
    input  wire logic [NVM_WORD_W-1:0] base,
    input  wire logic                  nvm_rd,
    input  wire logic [NVM_ADDR_W-1:0] nvm_addr,
    output var  logic [NVM_WORD_W-1:0] nvm_rdata,
    output var  logic                  nvm_rvalid
);
    int wait_cnt = 0;
    // idle data toggles each cycle so a stale word is never mistaken as valid
    always @(posedge clk_sys) begin
        if (nvm_rd) wait_cnt <= slow ? 4 : 1;
        else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
        if (!nvm_rd && wait_cnt == 1) begin
            nvm_rvalid <= 1'b1;
            nvm_rdata  <= base + 8'(nvm_addr);
        end else begin
            nvm_rvalid <= 1'b0;
            nvm_rdata  <= ~nvm_rdata;
        end
    end
endmodule : nvm_model
`default_nettype wire

// ---- tb/test_display_reset_sequencer.sv ----
// self-checking bench for the display reset sequencer
`timescale 1ns/10ps
`default_nettype none
module test_display_reset_sequencer;
    import display_reset_pkg::*;
    typedef struct packed {logic [7:0] low; logic awake; logic hit;} row_t;
    // pin low lengths around the filter threshold of 8 cycles
    localparam row_t ROWS [5] = '{'{8'h03, 1'b1, 1'b0}, '{8'h07, 1'b1, 1'b0},
        '{8'h0C, 1'b1, 1'b1}, '{8'h0C, 1'b0, 1'b1}, '{8'h28, 1'b1, 1'b1}};
    logic clk_sys = 1'b0;
    logic rstn, pin, awake_mode, slow, nvm_rd, nvm_rvalid, clk_en;
    logic display_blank, in_reset, defaults_load, config_ready;
    logic [7:0] base, nvm_rdata;
    logic [2:0] nvm_addr;
    logic [39:0] nvm_image, exp_img;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_dflt = 0;
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (defaults_load === 1'b1) n_dflt++;
    display_reset_sequencer #(.BLANK_CYCLES(20), .FILTER_CYC(8)) DUT (
        .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
        .hw_reset_low_pin(pin), .awake_mode(awake_mode), .nvm_rd(nvm_rd),
        .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata), .nvm_rvalid(nvm_rvalid),
        .display_blank(display_blank), .in_reset(in_reset),
        .defaults_load(defaults_load), .config_ready(config_ready),
        .nvm_image(nvm_image));
    nvm_model u_nvm (.clk_sys(clk_sys), .slow(slow), .base(base),
        .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata),
        .nvm_rvalid(nvm_rvalid));
    task check(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task results();
        if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    // host pin pulse; reset requests hold the pin well past the filter
    task pulse(input int n);
        @(negedge clk_sys) pin = 1'b0;
        repeat (n) @(negedge clk_sys);
        pin = 1'b1;
    endtask : pulse
    // wait past the filter time for a settled, loaded sequencer
    // the host sends nothing before ready, so its waits hold
    task settle(output logic seen);
        int k;
        seen = in_reset;
        for (k = 0; k < 600; k++) begin
            @(negedge clk_sys);
            seen |= in_reset;
            if (k > 24 && !in_reset && config_ready === 1'b1) break;
        end
        if (k == 600) begin
            n_mismatch++;
            results();
        end
    endtask : settle
    initial begin
        logic seen;
        int i;
        rstn = 0; pin = 1; awake_mode = 1; slow = 0; base = 8'h10;
        clk_en = 1'b1;
        repeat (8) @(negedge clk_sys);
        check(in_reset, 1'b1);
        check(nvm_image, '0);
        rstn = 1;
        settle(seen);
        exp_img = {8'h14, 8'h13, 8'h12, 8'h11, 8'h10};
        check(nvm_image, exp_img);
        for (i = 0; i < 5; i++) begin
            awake_mode = ROWS[i].awake; slow = i[0]; base = 8'(8'h20 + i * 16);
            n_dflt = 0;
            pulse(ROWS[i].low);
            settle(seen);
            if (ROWS[i].hit) exp_img = {base+8'h4, base+8'h3, base+8'h2, base+8'h1, base};
            check(seen, ROWS[i].hit);
            check(n_dflt, ROWS[i].hit);
            check(nvm_image, exp_img);
        end
        // frozen enable: a pin low that the filter never samples is lost
        n_dflt = 0; clk_en = 1'b0;
        pulse(12);
        repeat (2) @(negedge clk_sys);
        clk_en = 1'b1;
        repeat (12) @(negedge clk_sys);
        check({in_reset, config_ready}, 2'b01);
        check(n_dflt, 0);
        // spike inside a held reset: one reset, one defaults pulse
        n_dflt = 0; base = 8'h80;
        pulse(12);
        repeat (3) @(negedge clk_sys);
        check(in_reset, 1'b1);
        pulse(12);
        settle(seen);
        check(n_dflt, 1);
        check(nvm_image, {8'h84, 8'h83, 8'h82, 8'h81, 8'h80});
        // reset arriving mid-load restarts the image from word zero
        n_dflt = 0; base = 8'h40; slow = 1; awake_mode = 0;
        pulse(12);
        for (i = 0; i < 200 && nvm_rd !== 1'b1; i++) @(negedge clk_sys);
        if (i == 200) begin
            n_mismatch++;
            results();
        end
        repeat (6) @(negedge clk_sys);
        // new data from here: a load that resumed would keep word zero old
        base = 8'h50;
        pulse(12);
        settle(seen);
        check(n_dflt, 2);
        check(nvm_image, {8'h54, 8'h53, 8'h52, 8'h51, 8'h50});
        // second controller reset mid-run clears and reloads
        rstn = 0; base = 8'h60;
        repeat (8) @(negedge clk_sys);
        check({config_ready, in_reset}, 2'b01);
        check(nvm_image, 40'h0000000000);
        rstn = 1;
        settle(seen);
        check(nvm_image, {8'h64, 8'h63, 8'h62, 8'h61, 8'h60});
        results();
    end
endmodule : test_display_reset_sequencer
`default_nettype wire
